//--- sac_pkg.sv
// package: register map, field layout and timing constants for the converter control block
package sac_pkg;
	// register word offsets (the byte address on the avalon bus is the offset shifted up by ADR_LSB)
	localparam logic [3:0] ADR_DATA_LO  = 4'h0;
	localparam logic [3:0] ADR_DATA_HI  = 4'h1;
	localparam logic [3:0] ADR_SELECT   = 4'h2;
	localparam logic [3:0] ADR_COMMAND  = 4'h3;
	localparam logic [3:0] ADR_CHANNEL  = 4'h4;
	localparam logic [3:0] ADR_TYPE     = 4'h5;
	localparam logic [3:0] ADR_HOSTCTL  = 4'h6;
	localparam logic [3:0] ADR_GAIN     = 4'h7;
	localparam int         ADR_LSB      = 2;
	// command / status bit positions
	localparam int CMD_GO      = 0;
	localparam int ST_DONE     = 1;
	localparam int ST_ERROR    = 2;
	localparam int ST_TIMEOUT  = 3;
	localparam int ST_RUNNING  = 4;
	localparam int ST_RELEASE  = 5;
	localparam int ST_INTMUX   = 6;
	localparam int HC_ACK      = 0;
	// selection byte fields
	localparam int SEL_MUX_LO  = 5;
	localparam int SEL_MUX_HI  = 7;
	// converter geometry
	localparam int          RES_BITS   = 12;
	localparam logic [11:0] CODE_ZERO  = 12'h800;
	localparam logic [11:0] CODE_TOP   = 12'hfff;
	localparam int          INT_CH_SE  = 16;
	localparam int          INT_CH_DIF = 8;
	localparam int          EXT_CH_SE  = 240;
	localparam int          EXT_CH_DIF = 120;
	// timing: subsystem clock 100 khz derived from 40 mhz
	localparam int CLK_HZ        = 40_000_000;
	localparam int SYS_CLK_HZ    = 100_000;
	localparam int SYS_DIV       = CLK_HZ / SYS_CLK_HZ;
	localparam int TIMEOUT_US    = 200;
	localparam int TIMEOUT_TICKS = TIMEOUT_US * SYS_CLK_HZ / 1_000_000;
	localparam int TEST_RAMP_W   = 12;
	// avalon request carrier
	typedef struct packed {
		logic [3:0] addr;
		logic       rd;
		logic       wr;
		logic [7:0] wdata;
	} sac_req_s;
	// handshake state
	typedef enum logic [2:0] {
		HS_IDLE, HS_WAIT_RDY, HS_NULL, HS_CONVERT, HS_RELEASE
	} sac_hs_e;
endpackage : sac_pkg

//--- sac_sync.sv
// two flip-flop synchroniser for one level from the backplane
`timescale 1ns/10ps
module sac_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// level in and out
	input  wire logic din,
	output logic      dout
);
	logic meta_ff;
	// meta_ff is read only by dout
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= 1'b0;
			dout    <= 1'b0;
		end else begin
			meta_ff <= din;
			dout    <= meta_ff;
		end
	end
endmodule // sac_sync

//--- sac_sar.sv
// successive approximation register: one trial bit per step, msb first
`timescale 1ns/10ps
module sac_sar
	import sac_pkg::*;
(
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst_b,
	// control
	input  wire logic                start,
	input  wire logic                step,
	input  wire logic                comp_above,
	// trial and result
	output logic [RES_BITS-1:0]      trial,
	output logic                     done
);
	logic [RES_BITS-1:0] trial_ff;
	logic [RES_BITS-1:0] bit_ff;
	logic                done_ff;
	assign trial = trial_ff;
	assign done  = done_ff;
	// keep the trial bit if the residual exceeds its weight, then try the next lower one
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			trial_ff <= '0;
			bit_ff   <= '0;
			done_ff  <= 1'b0;
		end else if (start) begin
			trial_ff <= CODE_ZERO; // msb trial first
			bit_ff   <= CODE_ZERO;
			done_ff  <= 1'b0;
		end else if (step && bit_ff != '0) begin
			trial_ff <= (comp_above ? trial_ff : (trial_ff & ~bit_ff)) | (bit_ff >> 1);
			bit_ff   <= bit_ff >> 1;
			done_ff  <= (bit_ff == 12'h001);
		end else begin
			done_ff  <= 1'b0;
		end
	end
endmodule // sac_sar

//--- sac_ctrl.sv
// converter control: avalon registers, expander handshake, mux select and sar sequencing
//
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/10ps
module sac_ctrl
	import sac_pkg::*;
(
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rst_b,
	// avalon-mm slave
	input  wire logic [3:0]    avs_address,
	input  wire logic          avs_read,
	input  wire logic          avs_write,
	input  wire logic [7:0]    avs_writedata,
	output logic      [7:0]    avs_readdata,
	output logic               avs_waitrequest,
	// backplane handshake
	input  wire logic          bus_init,
	input  wire logic          expander_settled_line,
	input  wire logic          expander_fault_line,
	output logic               expander_select_strobe,
	output logic               offset_null_line,
	output logic               expander_release,
	// analog front end control
	input  wire logic          single_ended_sw,
	input  wire logic          comp_above,
	output logic [RES_BITS-1:0] dac_code,
	output logic [3:0]         int_channel,
	output logic               ext_mux_sel,
	output logic               neg_input_gnd,
	output logic [1:0]         test_src,
	output logic               test_en,
	output logic               sample_hold
);
	parameter logic [7:0] TYPE_CODE = 8'h5a; // arbitrary identification value
	localparam logic [8:0] DIV_LAST = 9'(SYS_DIV - 1);
	localparam logic [7:0] TO_LAST  = 8'(TIMEOUT_TICKS);

	sac_req_s req;
	sac_hs_e  hs_ff;
	logic       rdy_s, fault_s, init_s;
	logic [8:0] div_ff;
	logic       tick_ff;
	logic [7:0] select_ff, channel_ff, gain_ff, hostctl_ff;
	logic       intmux_ff, done_ff, error_ff, timeout_ff, running_ff, release_ff;
	logic [7:0] to_cnt_ff;
	logic       go_pend_ff, strobe_ff, ack_ff;
	logic [RES_BITS-1:0] result_ff, sar_trial;
	logic       sar_start, sar_done;
	logic       wr_sel, wr_cmd, rd_ack;
	logic       sen_s;

	assign req = '{addr: avs_address, rd: avs_read, wr: avs_write, wdata: avs_writedata};

	// backplane levels cross in through two flops each
	sac_sync u_rdy (.clk(clk), .rst_b(rst_b), .din(expander_settled_line), .dout(rdy_s));
	sac_sync u_flt (.clk(clk), .rst_b(rst_b), .din(expander_fault_line), .dout(fault_s));
	sac_sync u_ini (.clk(clk), .rst_b(rst_b), .din(bus_init), .dout(init_s));
	// the input mode switch is a front-panel pin, so it crosses like the others
	sac_sync u_sen (.clk(clk), .rst_b(rst_b), .din(single_ended_sw), .dout(sen_s));

	// bus slave answers one cycle after a request: waitrequest is low for the one edge at which ack_ff is high
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) ack_ff <= 1'b0;
		else        ack_ff <= (req.rd || req.wr) && !ack_ff;
	end
	// waitrequest from its own flop: low exactly while ack_ff is high
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) avs_waitrequest <= 1'b1;
		else        avs_waitrequest <= !((req.rd || req.wr) && !ack_ff);
	end
	assign wr_sel = ack_ff && req.wr && req.addr == ADR_SELECT;
	assign wr_cmd = ack_ff && req.wr && req.addr == ADR_COMMAND;
	// acknowledge read of the data with the acknowledge bit set
	assign rd_ack = ack_ff && req.rd && hostctl_ff[HC_ACK] &&
		(req.addr == ADR_DATA_LO || req.addr == ADR_DATA_HI);

	// readback mux registered so data stands at the accepting edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) avs_readdata <= 8'h00;
		else if (req.rd && !ack_ff) begin
			unique case (req.addr)
				ADR_DATA_LO: avs_readdata <= result_ff[7:0];
				ADR_DATA_HI: avs_readdata <= {4'h0, result_ff[11:8]};
				ADR_SELECT:  avs_readdata <= select_ff;
				ADR_COMMAND: avs_readdata <= {1'b0, intmux_ff, release_ff, running_ff,
					timeout_ff, error_ff, done_ff, 1'b0};
				ADR_CHANNEL: avs_readdata <= channel_ff;
				ADR_TYPE:    avs_readdata <= TYPE_CODE;
				ADR_HOSTCTL: avs_readdata <= hostctl_ff;
				ADR_GAIN:    avs_readdata <= gain_ff;
				default:     avs_readdata <= 8'h00;
			endcase
		end
	end

	// software-written setup registers; bus init wipes selection
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			select_ff  <= 8'h00;
			channel_ff <= 8'h00;
			gain_ff    <= 8'h00;
			hostctl_ff <= 8'h00;
			intmux_ff  <= 1'b0;
		end else if (init_s) begin
			select_ff <= 8'h00;
			intmux_ff <= 1'b0;
		end else if (ack_ff && req.wr) begin
			unique case (req.addr)
				ADR_SELECT: begin
					select_ff <= req.wdata;
					intmux_ff <= (req.wdata[SEL_MUX_HI:SEL_MUX_LO] == 3'b000);
				end
				ADR_CHANNEL: channel_ff <= req.wdata;
				ADR_GAIN:    gain_ff    <= req.wdata;
				ADR_HOSTCTL: hostctl_ff <= req.wdata;
				default: ;
			endcase
		end
	end

	// 100 khz subsystem tick; the go write lands at any clock, the sequence waits for a tick
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div_ff  <= '0;
			tick_ff <= 1'b0;
		end else begin
			div_ff  <= (div_ff == DIV_LAST) ? 9'd0 : div_ff + 9'd1;
			tick_ff <= (div_ff == DIV_LAST);
		end
	end

	// expander strobe: one cycle on nonzero mux select write and on go write while the internal mux is not selected
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) strobe_ff <= 1'b0;
		else strobe_ff <= (wr_sel && req.wdata[SEL_MUX_HI:SEL_MUX_LO] != 3'b000)
			|| (wr_cmd && req.wdata[CMD_GO] && !intmux_ff);
	end
	assign expander_select_strobe = strobe_ff;

	// go request held until a subsystem tick finds the handshake in HS_IDLE
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) go_pend_ff <= 1'b0;
		else if (init_s) go_pend_ff <= 1'b0;
		else if (wr_cmd && req.wdata[CMD_GO] && !release_ff) go_pend_ff <= 1'b1;
		else if (tick_ff && hs_ff == HS_IDLE) go_pend_ff <= 1'b0;
	end

	assign sar_start = tick_ff && hs_ff == HS_NULL && (intmux_ff || !rdy_s);

	// handshake sequence: idle, wait and null steps advance on the subsystem tick, convert and release on any clock
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) hs_ff <= HS_IDLE;
		else if (init_s) hs_ff <= HS_IDLE;
		else begin
			unique case (hs_ff)
				HS_IDLE:     if (tick_ff && go_pend_ff) hs_ff <= HS_WAIT_RDY;
				HS_WAIT_RDY: if (tick_ff && (intmux_ff || rdy_s)) hs_ff <= HS_NULL;
					else if (timeout_ff) hs_ff <= HS_IDLE;
				HS_NULL:     if (sar_start) hs_ff <= HS_CONVERT;
				HS_CONVERT:  if (sar_done) hs_ff <= HS_RELEASE;
				HS_RELEASE:  if (!release_ff) hs_ff <= HS_IDLE;
			endcase
		end
	end

	// running flop drives the offset-null line
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) running_ff <= 1'b0;
		else if (init_s || sar_done) running_ff <= 1'b0;
		else if (hs_ff == HS_WAIT_RDY && tick_ff && (intmux_ff || rdy_s)) running_ff <= 1'b1;
	end
	assign offset_null_line = running_ff;

	// release stays up until the acknowledged data read
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) release_ff <= 1'b0;
		else if (sar_done) release_ff <= 1'b1;
		else if (init_s || rd_ack) release_ff <= 1'b0;
	end
	assign expander_release = release_ff;

	// sar core steps once per clock; zero input yields 0x800 offset binary
	sac_sar u_sar (.clk(clk), .rst_b(rst_b), .start(sar_start),
		.step(hs_ff == HS_CONVERT), .comp_above(comp_above),
		.trial(sar_trial), .done(sar_done));
	assign dac_code = sar_trial;

	// result latch: 12-bit offset binary, top code 0xfff one step under plus full scale
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) result_ff <= CODE_ZERO;
		else if (sar_done) result_ff <= sar_trial;
	end

	// sticky status: hardware set beats the acknowledge clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			done_ff    <= 1'b0;
			error_ff   <= 1'b0;
			timeout_ff <= 1'b0;
		end else begin
			if (sar_done) done_ff <= 1'b1;
			else if (init_s || rd_ack) done_ff <= 1'b0;
			if (fault_s) error_ff <= 1'b1;
			else if (init_s || (rd_ack && !done_ff)) error_ff <= 1'b0;
			if (tick_ff && hs_ff == HS_WAIT_RDY && to_cnt_ff == TO_LAST) timeout_ff <= 1'b1;
			else if (init_s || (rd_ack && !done_ff && !error_ff)) timeout_ff <= 1'b0;
		end
	end

	// timeout counter runs from go until ready
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) to_cnt_ff <= '0;
		else if (hs_ff != HS_WAIT_RDY) to_cnt_ff <= '0;
		else if (tick_ff && to_cnt_ff != TO_LAST) to_cnt_ff <= to_cnt_ff + 8'd1;
	end

	// mux select: channel by input mode, test source, minus grounded when single-ended
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			int_channel   <= 4'h0;
			ext_mux_sel   <= 1'b0;
			neg_input_gnd <= 1'b0;
			test_src      <= 2'b00;
			test_en       <= 1'b0;
			sample_hold   <= 1'b0;
		end else begin
			int_channel   <= sen_s ? channel_ff[3:0] : {1'b0, channel_ff[2:0]};
			ext_mux_sel   <= !intmux_ff;
			neg_input_gnd <= sen_s;
			test_src      <= gain_ff[1:0];
			test_en       <= gain_ff[7];
			sample_hold   <= running_ff || hs_ff == HS_CONVERT;
		end
	end

	chk_rel_hold: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(release_ff) |-> $past(rd_ack) || $past(init_s)) else $error("release dropped early");
	chk_done_rel: assert property (@(posedge clk) disable iff (!rst_b)
		sar_done |=> release_ff && !running_ff && done_ff) else $error("completion bad");
	chk_err_set: assert property (@(posedge clk) disable iff (!rst_b)
		fault_s |=> error_ff) else $error("fault not flagged");
	chk_conv_gate: assert property (@(posedge clk) disable iff (!rst_b)
		sar_start |-> intmux_ff || !rdy_s) else $error("convert with ready high");
	chk_null_line: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(running_ff) |-> $past(hs_ff) == HS_WAIT_RDY) else $error("null out of order");
	chk_strobe_pulse: assert property (@(posedge clk) disable iff (!rst_b)
		strobe_ff |=> !strobe_ff) else $error("strobe too long");
	chk_sel_int: assert property (@(posedge clk) disable iff (!rst_b)
		wr_sel && !init_s |=> intmux_ff == ($past(req.wdata[7:5]) == 3'b000)) else $error("intmux bad");
	chk_init_idle: assert property (@(posedge clk) disable iff (!rst_b)
		init_s |=> hs_ff == HS_IDLE && !running_ff) else $error("init missed");
	cov_conv: cover property (@(posedge clk) disable iff (!rst_b) sar_done);
	cov_ack: cover property (@(posedge clk) disable iff (!rst_b) rd_ack && release_ff);
	cov_to: cover property (@(posedge clk) disable iff (!rst_b) $rose(timeout_ff));
endmodule // sac_ctrl

//--- sac_expander_model.sv
// behavioural expansion multiplexer on the far side of the handshake
`timescale 1ns/10ps
module sac_expander_model #(
	parameter int SETTLE = 600
) (
	// clock and reset
	input  wire logic  clk,
	input  wire logic  rst_b,
	// handshake from the converter
	input  wire logic  expander_select_strobe,
	input  wire logic  offset_null_line,
	input  wire logic  expander_release,
	// bench controls: bad selection, never settle
	input  wire logic  bad_sel,
	input  wire logic  stall,
	// handshake back and state for the bench
	output logic       expander_settled_line,
	output wire logic  expander_fault_line,
	output logic       sel_ff,
	output logic [3:0] strobes
);
	logic go_ff;
	int   dly;
	// only the addressed expander reports a bad channel or gain
	assign expander_fault_line = bad_sel && sel_ff;
	// first strobe selects, second triggers; release returns to idle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sel_ff <= 1'b0;
			go_ff <= 1'b0;
			expander_settled_line <= 1'b0;
			strobes <= 4'h0;
			dly <= 0;
		end else if (expander_release) begin
			sel_ff <= 1'b0;
			go_ff <= 1'b0;
			expander_settled_line <= 1'b0;
		end else if (expander_select_strobe) begin
			strobes <= strobes + 4'h1;
			sel_ff <= 1'b1;
			go_ff <= sel_ff;
			dly <= 0;
		end else if (go_ff && !stall) begin
			// ready drops only once the null phase has had time to settle
			dly <= dly + 1;
			if (dly == SETTLE) expander_settled_line <= 1'b1;
			if (offset_null_line && dly > SETTLE + 200) expander_settled_line <= 1'b0;
		end
	end
endmodule // sac_expander_model

//--- test_sar_adc_mux_handshake_control.sv
// self-checking bench for the converter control block and its expander handshake
`timescale 1ns/10ps
module test_sar_adc_mux_handshake_control;
	import sac_pkg::*;
	logic        clk, rst_b, rd, wr, bus_init, sw, bad_sel, stall;
	logic [3:0]  adr, ich, strobes, s0;
	logic [7:0]  wd, rdat, q;
	logic        wt, rdy, flt, stb, nul, rel, ext, gnd, ten, sel_ff, sh;
	logic [11:0] vin, dac;
	logic [1:0]  tsrc;
	logic [31:0] seed, t;
	int          err_total, comparisons;
	wire  [2:0]  watch = {stb, nul, rel};
	// the comparator stands in for the analog input at level vin
	wire         above = (vin >= dac);
	sac_ctrl sac_ctrl_inst (.clk(clk), .rst_b(rst_b), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wt), .bus_init(bus_init),
		.expander_settled_line(rdy), .expander_fault_line(flt), .expander_select_strobe(stb),
		.offset_null_line(nul), .expander_release(rel), .single_ended_sw(sw), .comp_above(above),
		.dac_code(dac), .int_channel(ich), .ext_mux_sel(ext), .neg_input_gnd(gnd), .test_src(tsrc),
		.test_en(ten), .sample_hold(sh));
	sac_expander_model sac_expander_model_inst (.clk(clk), .rst_b(rst_b), .expander_select_strobe(stb),
		.offset_null_line(nul), .expander_release(rel), .bad_sel(bad_sel), .stall(stall),
		.expander_settled_line(rdy), .expander_fault_line(flt), .sel_ff(sel_ff), .strobes(strobes));
	// 40 mhz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// expected code: trial bits msb first, kept when the input reaches them
	function automatic logic [11:0] sar_exp(input logic [11:0] v);
		logic [11:0] acc;
		acc = 12'h000;
		for (int b = 11; b >= 0; b--) begin
			if (v >= (acc | (12'h001 << b))) acc = acc | (12'h001 << b);
		end
		return acc;
	endfunction
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic hang(input string what);
		err_total++;
		$display("mismatch %s expected answer seen none", what);
		give_verdict();
	endtask
	// one avalon transfer held until waitrequest is sampled low; read data lands in q
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wt !== 1'b0 && n < 50);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 50) hang("waitrequest");
	endtask
	// bounded wait for strobe, null or release to reach a level
	task automatic wait_for(input int k, input logic v, input int lim);
		int n;
		n = 0;
		while (watch[k] !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (n >= lim) hang("handshake");
	endtask
	// one conversion from the go write to the acknowledged data read
	task automatic convert(input logic [11:0] v, input logic x);
		logic [7:0] lo;
		vin <= v;
		bus(1'b1, ADR_COMMAND, 8'h01);
		if (x) begin
			wait_for(1, 1'b1, 4000);
			check("ready at null", rdy, 1'b1);
		end
		wait_for(0, 1'b1, 12000);
		check("null after done", nul, 1'b0);
		bus(1'b0, ADR_COMMAND, 8'h00);
		check("done bit", q[ST_DONE], 1'b1);
		check("hold ended", sh, 1'b0);
		bus(1'b0, ADR_DATA_LO, 8'h00);
		check("release held", rel, 1'b1);
		bus(1'b1, ADR_HOSTCTL, 8'h01);
		bus(1'b0, ADR_DATA_LO, 8'h00);
		lo = q;
		bus(1'b0, ADR_DATA_HI, 8'h00);
		check("result", {q[3:0], lo}, sar_exp(v));
		check("release dropped", rel, 1'b0);
		bus(1'b1, ADR_HOSTCTL, 8'h00);
	endtask
	initial begin
		{rst_b, rd, wr, bus_init, sw, bad_sel, stall} = 7'h00;
		{adr, wd, vin} = 24'h0000_00;
		seed = 32'ha345;
		err_total = 0;
		comparisons = 0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		// identification code, an unmapped place and idle handshake
		bus(1'b0, ADR_TYPE, 8'h00);
		check("type code", q, 8'h5a);
		bus(1'b1, 4'h8, 8'hff);
		bus(1'b0, 4'h8, 8'h00);
		check("unmapped", q, 8'h00);
		check("idle lines", {stb, nul, rel}, 3'h0);
		$display("test reset done");
		// internal mux, channel and test source for every source code
		bus(1'b1, ADR_SELECT, 8'h00);
		bus(1'b0, ADR_COMMAND, 8'h00);
		check("internal select", q[ST_INTMUX], 1'b1);
		check("no strobe", strobes, 4'h0);
		for (int i = 0; i < 4; i++) begin
			t = rnd();
			sw <= t[8];
			bus(1'b1, ADR_CHANNEL, {4'h0, t[3:0]});
			bus(1'b1, ADR_GAIN, {1'b1, 5'h00, 2'(i)});
			repeat (3) @(posedge clk);
			if (t[8]) check("int channel", ich, t[3:0]);
			else check("diff channel", ich, {1'b0, t[2:0]});
			check("mux select", {ext, gnd}, {1'b0, t[8]});
			check("test source", {ten, tsrc}, {1'b1, 2'(i)});
			bus(1'b0, ADR_CHANNEL, 8'h00);
			check("channel readback", q, {4'h0, t[3:0]});
		end
		bus(1'b1, ADR_GAIN, 8'h00);
		$display("test selection done");
		// internal conversions over the code corners and random levels
		for (int i = 0; i < 6; i++) begin
			t = rnd();
			bus(1'b1, ADR_SELECT, 8'h00);
			convert(i == 0 ? CODE_ZERO : i == 1 ? CODE_TOP : i == 2 ? 12'h000 : t[11:0], 1'b0);
		end
		$display("test internal done");
		// expander handshake: strobe, go strobe, ready, null, release
		s0 = strobes;
		bus(1'b1, ADR_SELECT, 8'h20);
		repeat (4) @(posedge clk);
		check("select strobe", strobes, s0 + 4'h1);
		check("expander selected", {sel_ff, ext}, 2'b11);
		t = rnd();
		convert(t[11:0], 1'b1);
		check("go strobe", strobes, s0 + 4'h2);
		check("expander freed", sel_ff, 1'b0);
		$display("test expander done");
		// fault from the expander, cleared by an acknowledged read
		bus(1'b1, ADR_SELECT, 8'h20);
		bad_sel <= 1'b1;
		repeat (6) @(posedge clk);
		bus(1'b0, ADR_COMMAND, 8'h00);
		check("error bit", q[ST_ERROR], 1'b1);
		bad_sel <= 1'b0;
		bus(1'b1, ADR_HOSTCTL, 8'h01);
		bus(1'b0, ADR_DATA_LO, 8'h00);
		bus(1'b1, ADR_HOSTCTL, 8'h00);
		bus(1'b0, ADR_COMMAND, 8'h00);
		check("error cleared", q[ST_ERROR], 1'b0);
		$display("test fault done");
		// expander never settles: timeout, then bus initialisation
		stall <= 1'b1;
		bus(1'b1, ADR_COMMAND, 8'h01);
		repeat (TIMEOUT_TICKS * SYS_DIV + 1200) @(posedge clk);
		bus(1'b0, ADR_COMMAND, 8'h00);
		check("timeout bit", q[ST_TIMEOUT], 1'b1);
		bus_init <= 1'b1;
		repeat (4) @(posedge clk);
		bus_init <= 1'b0;
		repeat (4) @(posedge clk);
		bus(1'b0, ADR_COMMAND, 8'h00);
		check("init clears", {q[ST_RELEASE], q[ST_RUNNING], q[ST_DONE], q[ST_ERROR], nul, rel}, 6'h00);
		$display("test timeout done");
		give_verdict();
	end
endmodule // test_sar_adc_mux_handshake_control
